// ==== ctu_pkg.sv ====
// shared constants and source decoding for the charge time unit control
package ctu_pkg;

    // register index on the plain register port
    localparam logic [1:0]  CTU_ADDR_UNIT_CTRL = 2'h0;
    localparam logic [1:0]  CTU_ADDR_EDGE_CTRL = 2'h1;
    localparam logic [1:0]  CTU_ADDR_CUR_CTRL  = 2'h2;

    // unit_control_one fields
    localparam int          CTU_BIT_ENABLE     = 15;
    localparam int          CTU_BIT_IDLE_STOP  = 13;
    localparam int          CTU_BIT_HW_EDGE    = 11;
    localparam int          CTU_BIT_ORDER      = 10;
    localparam int          CTU_BIT_SINK       = 9;
    localparam int          CTU_BIT_TRIG       = 8;

    // edge_control fields
    localparam int          CTU_BIT_A_SENSE    = 15;
    localparam int          CTU_BIT_A_POL      = 14;
    localparam int          CTU_LSB_A_SOURCE   = 10;
    localparam int          CTU_BIT_B_FLAG     = 9;
    localparam int          CTU_BIT_A_FLAG     = 8;
    localparam int          CTU_BIT_B_SENSE    = 7;
    localparam int          CTU_BIT_B_POL      = 6;
    localparam int          CTU_LSB_B_SOURCE   = 2;

    // current_source_control fields
    localparam int          CTU_LSB_TRIM       = 10;
    localparam int          CTU_LSB_RANGE      = 8;

    // implemented bits; everything else reads as zero
    localparam logic [15:0] CTU_MASK_UNIT_CTRL = 16'hAF00;
    localparam logic [15:0] CTU_MASK_EDGE_CTRL = 16'hFFFC;
    localparam logic [15:0] CTU_MASK_CUR_CTRL  = 16'hFF00;

    // reset values
    localparam logic [15:0] CTU_RST_UNIT_CTRL  = 16'h0000;
    localparam logic [15:0] CTU_RST_EDGE_CTRL  = 16'h0000;
    localparam logic [15:0] CTU_RST_CUR_CTRL   = 16'h0000;

    // edge source codes
    localparam logic [3:0]  CTU_SRC_TIMER_CAP  = 4'h0;
    localparam logic [3:0]  CTU_SRC_COMPARE    = 4'h1;
    localparam logic [3:0]  CTU_SRC_PIN_A      = 4'h2;
    localparam logic [3:0]  CTU_SRC_PIN_B      = 4'h3;

    // current range codes
    localparam logic [1:0]  CTU_RNG_X1000      = 2'h0;
    localparam logic [1:0]  CTU_RNG_X1         = 2'h1;
    localparam logic [1:0]  CTU_RNG_X10        = 2'h2;
    localparam logic [1:0]  CTU_RNG_X100       = 2'h3;

    // reserved codes select a level that stays low
    function automatic logic ctu_pick_source(
        input logic [3:0] sel,
        input logic       first_src,
        input logic       compare_src,
        input logic       pin_a,
        input logic       pin_b
    );
        logic lvl;
        lvl = 1'b0;
        case (sel)
            CTU_SRC_TIMER_CAP: lvl = first_src;
            CTU_SRC_COMPARE:   lvl = compare_src;
            CTU_SRC_PIN_A:     lvl = pin_a;
            CTU_SRC_PIN_B:     lvl = pin_b;
            default:           lvl = 1'b0;
        endcase
        return lvl;
    endfunction : ctu_pick_source

endpackage : ctu_pkg

// ==== ctu_edge_sense.sv ====
// edge or level detector for one edge channel
module ctu_edge_sense (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic level,
    input  wire logic polarity,
    input  wire logic sense,
    input  wire logic enable,
    output logic      hit
);

    typedef struct packed {
        logic prev_active;
    } ctu_sense_state_t;

    ctu_sense_state_t s_r;
    ctu_sense_state_t s_nxt;
    logic             active;

    // polarity 1 answers a rising source, 0 a falling one
    assign active = polarity ? level : ~level;

    always_comb begin
        s_nxt             = s_r;
        s_nxt.prev_active = active;
        // sense 1 is level sensitive, 0 edge sensitive
        if (!enable) begin
            hit = 1'b0;
        end else if (sense) begin
            hit = active;
        end else begin
            hit = active & ~s_r.prev_active;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : ctu_edge_sense

// ==== ctu_unit.sv ====
// charge time unit control: registers, edge channels and analog controls
//
// Chosen here: the register addresses and strobed register access.
module ctu_unit (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        idle_mode,
    input  wire logic        timer_source,
    input  wire logic        capture_in_one,
    input  wire logic        compare_out_one,
    input  wire logic        ext_edge_pin_a,
    input  wire logic        ext_edge_pin_b,
    output logic             unit_running,
    output logic             charge_on,
    output logic             current_sink_ground,
    output logic             conv_start,
    output logic      [1:0]  current_range,
    output logic      [5:0]  current_trim,
    output logic             edge_a_flag,
    output logic             edge_b_flag
);

    typedef struct packed {
        logic [1:0]  pin_a_s;
        logic [1:0]  pin_b_s;
        logic        enable;
        logic        idle_stop;
        logic        hw_edge;
        logic        order;
        logic        sink;
        logic        trig_en;
        logic        a_sense;
        logic        a_pol;
        logic [3:0]  a_source;
        logic        b_sense;
        logic        b_pol;
        logic [3:0]  b_source;
        logic        flag_a;
        logic        flag_b;
        logic [5:0]  trim;
        logic [1:0]  range;
        logic [15:0] rdata;
        logic        conv;
        logic        charge;
        logic        running;
    } ctu_state_t;

    ctu_state_t  s_r;
    ctu_state_t  s_nxt;
    logic [1:0]  rst_sync_r;
    logic        rst_n_s;
    logic        run;
    logic        hw_go;
    logic        lvl_a;
    logic        lvl_b;
    logic        hit_a;
    logic        hit_b;
    logic        src_ok_a;
    logic        src_ok_b;
    logic        set_a;
    logic        set_b;
    logic        wr_unit;
    logic        wr_edge;
    logic        wr_cur;
    logic [15:0] rd_unit;
    logic [15:0] rd_edge;
    logic [15:0] rd_cur;

    // reset released through two flip-flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync_r[1];

    assign wr_unit = reg_wr && (reg_addr == ctu_pkg::CTU_ADDR_UNIT_CTRL);
    assign wr_edge = reg_wr && (reg_addr == ctu_pkg::CTU_ADDR_EDGE_CTRL);
    assign wr_cur  = reg_wr && (reg_addr == ctu_pkg::CTU_ADDR_CUR_CTRL);

    // unit enable gated by idle stop
    assign run   = s_r.enable & ~(s_r.idle_stop & idle_mode);
    // hardware sources only with hw edge bit
    assign hw_go = run & s_r.hw_edge;
    // reserved codes never fire, whatever the polarity or sense
    assign src_ok_a = (s_r.a_source[3:2] == 2'h0);
    assign src_ok_b = (s_r.b_source[3:2] == 2'h0);

    // source select; pins use the second sync stage only
    assign lvl_a = ctu_pkg::ctu_pick_source(s_r.a_source, timer_source,
        compare_out_one, s_r.pin_a_s[1], s_r.pin_b_s[1]);
    assign lvl_b = ctu_pkg::ctu_pick_source(s_r.b_source, capture_in_one,
        compare_out_one, s_r.pin_a_s[1], s_r.pin_b_s[1]);

    ctu_edge_sense u_sense_a (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n_s),
        .level    (lvl_a),
        .polarity (s_r.a_pol),
        .sense    (s_r.a_sense),
        .enable   (hw_go & src_ok_a),
        .hit      (hit_a)
    );

    ctu_edge_sense u_sense_b (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n_s),
        .level    (lvl_b),
        .polarity (s_r.b_pol),
        .sense    (s_r.b_sense),
        .enable   (hw_go & src_ok_b),
        .hit      (hit_b)
    );

    assign set_a = hit_a;
    // with the order bit set, edge b refused until edge a has occurred
    assign set_b = hit_b & (~s_r.order | s_r.flag_a);

    // read views with unimplemented bits forced to zero
    always_comb begin
        rd_unit = 16'h0000;
        rd_unit[ctu_pkg::CTU_BIT_ENABLE]    = s_r.enable;
        rd_unit[ctu_pkg::CTU_BIT_IDLE_STOP] = s_r.idle_stop;
        rd_unit[ctu_pkg::CTU_BIT_HW_EDGE]   = s_r.hw_edge;
        rd_unit[ctu_pkg::CTU_BIT_ORDER]     = s_r.order;
        rd_unit[ctu_pkg::CTU_BIT_SINK]      = s_r.sink;
        rd_unit[ctu_pkg::CTU_BIT_TRIG]      = s_r.trig_en;
        rd_unit = rd_unit & ctu_pkg::CTU_MASK_UNIT_CTRL;
        rd_edge = 16'h0000;
        rd_edge[ctu_pkg::CTU_BIT_A_SENSE] = s_r.a_sense;
        rd_edge[ctu_pkg::CTU_BIT_A_POL]   = s_r.a_pol;
        rd_edge[ctu_pkg::CTU_LSB_A_SOURCE +: 4] = s_r.a_source;
        rd_edge[ctu_pkg::CTU_BIT_B_FLAG]  = s_r.flag_b;
        rd_edge[ctu_pkg::CTU_BIT_A_FLAG]  = s_r.flag_a;
        rd_edge[ctu_pkg::CTU_BIT_B_SENSE] = s_r.b_sense;
        rd_edge[ctu_pkg::CTU_BIT_B_POL]   = s_r.b_pol;
        rd_edge[ctu_pkg::CTU_LSB_B_SOURCE +: 4] = s_r.b_source;
        rd_edge = rd_edge & ctu_pkg::CTU_MASK_EDGE_CTRL;
        rd_cur  = 16'h0000;
        rd_cur[ctu_pkg::CTU_LSB_TRIM +: 6]  = s_r.trim;
        rd_cur[ctu_pkg::CTU_LSB_RANGE +: 2] = s_r.range;
        rd_cur  = rd_cur & ctu_pkg::CTU_MASK_CUR_CTRL;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.pin_a_s = {s_r.pin_a_s[0], ext_edge_pin_a};
        s_nxt.pin_b_s = {s_r.pin_b_s[0], ext_edge_pin_b};
        if (wr_unit) begin
            s_nxt.enable    = reg_wdata[ctu_pkg::CTU_BIT_ENABLE];
            s_nxt.idle_stop = reg_wdata[ctu_pkg::CTU_BIT_IDLE_STOP];
            s_nxt.hw_edge   = reg_wdata[ctu_pkg::CTU_BIT_HW_EDGE];
            s_nxt.order     = reg_wdata[ctu_pkg::CTU_BIT_ORDER];
            s_nxt.sink      = reg_wdata[ctu_pkg::CTU_BIT_SINK];
            s_nxt.trig_en   = reg_wdata[ctu_pkg::CTU_BIT_TRIG];
        end
        if (wr_edge) begin
            s_nxt.a_sense  = reg_wdata[ctu_pkg::CTU_BIT_A_SENSE];
            s_nxt.a_pol    = reg_wdata[ctu_pkg::CTU_BIT_A_POL];
            s_nxt.a_source = reg_wdata[ctu_pkg::CTU_LSB_A_SOURCE +: 4];
            s_nxt.b_sense  = reg_wdata[ctu_pkg::CTU_BIT_B_SENSE];
            s_nxt.b_pol    = reg_wdata[ctu_pkg::CTU_BIT_B_POL];
            s_nxt.b_source = reg_wdata[ctu_pkg::CTU_LSB_B_SOURCE +: 4];
        end
        if (wr_cur) begin
            s_nxt.trim  = reg_wdata[ctu_pkg::CTU_LSB_TRIM +: 6];
            s_nxt.range = reg_wdata[ctu_pkg::CTU_LSB_RANGE +: 2];
        end
        // write drives flags; a hardware edge wins
        if (wr_edge) begin
            s_nxt.flag_a = reg_wdata[ctu_pkg::CTU_BIT_A_FLAG] | set_a;
            s_nxt.flag_b = reg_wdata[ctu_pkg::CTU_BIT_B_FLAG] | set_b;
        end else begin
            s_nxt.flag_a = s_r.flag_a | set_a;
            s_nxt.flag_b = s_r.flag_b | set_b;
        end
        // one pulse to the ADC when edge b arrives with the trigger bit set
        s_nxt.conv    = run & s_r.trig_en & s_nxt.flag_b & ~s_r.flag_b;
        // current flows between edge a and edge b, never while sinking
        s_nxt.charge  = run & s_nxt.flag_a & ~s_nxt.flag_b & ~s_nxt.sink;
        s_nxt.running = run;
        s_nxt.rdata   = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                ctu_pkg::CTU_ADDR_UNIT_CTRL: s_nxt.rdata = rd_unit;
                ctu_pkg::CTU_ADDR_EDGE_CTRL: s_nxt.rdata = rd_edge;
                ctu_pkg::CTU_ADDR_CUR_CTRL:  s_nxt.rdata = rd_cur;
                default:                     s_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            s_r       <= '0;
        end else begin
            s_r       <= s_nxt;
        end
    end

    assign reg_rdata           = s_r.rdata;
    assign unit_running        = s_r.running;
    assign charge_on           = s_r.charge;
    // grounding follows only the sink bit
    assign current_sink_ground = s_r.sink;
    assign conv_start          = s_r.conv;
    assign current_range       = s_r.range;
    assign current_trim        = s_r.trim;
    assign edge_a_flag         = s_r.flag_a;
    assign edge_b_flag         = s_r.flag_b;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n_s);

    a_disabled_flags_hold: assert property (
        !s_r.enable && !wr_edge |=> $stable({edge_a_flag, edge_b_flag}))
        else $error("flags changed while unit disabled");

    a_idle_stop_halt: assert property (
        s_r.idle_stop && idle_mode |=> !unit_running && !charge_on)
        else $error("unit kept running in idle with idle stop set");

    a_sw_edges_only: assert property (
        !s_r.hw_edge && !wr_edge |=> $stable({edge_a_flag, edge_b_flag}))
        else $error("hardware edge accepted in software edge mode");

    a_order_refuse_b: assert property (
        s_r.order && !s_r.flag_a && !s_r.flag_b && !wr_edge
        |=> !edge_b_flag)
        else $error("edge b accepted before edge a");

    a_sink_follows_bit: assert property (
        wr_unit |=> current_sink_ground == $past(reg_wdata[9]))
        else $error("sink output does not follow written bit");

    a_conv_on_edge_b: assert property (
        conv_start |-> edge_b_flag && !$past(edge_b_flag)
        && $past(s_r.trig_en))
        else $error("conversion start without edge b or trigger bit");

    a_unimpl_read_zero: assert property (
        reg_rd |=> (reg_rdata & ~16'hFFFC) == 16'h0000
        && ($past(reg_addr) != 2'h0 || reg_rdata[14] == 1'b0)
        && ($past(reg_addr) != 2'h0 || reg_rdata[12] == 1'b0)
        && ($past(reg_addr) == 2'h1 || reg_rdata[7:0] == 8'h00))
        else $error("unimplemented bit read as one");

    a_flag_b_write: assert property (
        wr_edge && !s_r.hw_edge |=> edge_b_flag == $past(reg_wdata[9]))
        else $error("edge b flag not driven by write");

    a_flag_a_write: assert property (
        wr_edge && !s_r.hw_edge |=> edge_a_flag == $past(reg_wdata[8]))
        else $error("edge a flag not driven by write");

    a_range_trim_load: assert property (
        wr_cur |=> current_range == $past(reg_wdata[9:8])
        && current_trim == $past(reg_wdata[15:10]))
        else $error("range or trim not loaded");

    a_read_one_cycle: assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data held beyond one cycle");

endmodule : ctu_unit

// ==== ctu_src_model.sv ====
// model of the on-chip edge sources and the two edge pins
module ctu_src_model (
    input  wire logic       sys_clk,
    input  wire logic [4:0] lvl_req,
    output logic            timer_source,
    output logic            capture_in_one,
    output logic            compare_out_one,
    output logic            ext_edge_pin_a,
    output logic            ext_edge_pin_b
);
    timeunit 1ns;
    timeprecision 100ps;

    // sources start low and follow the request one clock later
    initial begin
        timer_source    = 1'b0;
        capture_in_one  = 1'b0;
        compare_out_one = 1'b0;
        ext_edge_pin_a  = 1'b0;
        ext_edge_pin_b  = 1'b0;
    end

    always @(posedge sys_clk) begin
        {ext_edge_pin_b, ext_edge_pin_a, compare_out_one} <= lvl_req[4:2];
        {capture_in_one, timer_source}                    <= lvl_req[1:0];
    end
endmodule : ctu_src_model

// ==== charge_time_edge_control_bench.sv ====
// self-checking bench for the charge time unit control
module charge_time_edge_control_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk;
    logic        reset_n;
    logic        reg_wr;
    logic        reg_rd;
    logic        idle_mode;
    logic [1:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [4:0]  lvl_req;
    logic        timer_source;
    logic        capture_in_one;
    logic        compare_out_one;
    logic        ext_edge_pin_a;
    logic        ext_edge_pin_b;
    logic        unit_running;
    logic        charge_on;
    logic        current_sink_ground;
    logic        conv_start;
    logic [1:0]  current_range;
    logic [5:0]  current_trim;
    logic        edge_a_flag;
    logic        edge_b_flag;
    int          mismatches;
    int          num_checks;
    int          conv_cnt;
    logic [5:0]  trim_tab [4] = '{6'h00, 6'h01, 6'h3F, 6'h20};

    ctu_unit u_ctu_unit (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
        .timer_source(timer_source), .capture_in_one(capture_in_one),
        .compare_out_one(compare_out_one), .ext_edge_pin_a(ext_edge_pin_a),
        .ext_edge_pin_b(ext_edge_pin_b), .unit_running(unit_running),
        .charge_on(charge_on), .current_sink_ground(current_sink_ground),
        .conv_start(conv_start), .current_range(current_range),
        .current_trim(current_trim), .edge_a_flag(edge_a_flag),
        .edge_b_flag(edge_b_flag));

    ctu_src_model u_ctu_src_model (.sys_clk(sys_clk), .lvl_req(lvl_req),
        .timer_source(timer_source), .capture_in_one(capture_in_one),
        .compare_out_one(compare_out_one), .ext_edge_pin_a(ext_edge_pin_a),
        .ext_edge_pin_b(ext_edge_pin_b));

    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    // counts conversion start pulses, one per high cycle
    always @(posedge sys_clk) begin
        if (conv_start === 1'b1) conv_cnt++;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [1:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk_word(reg_rdata, exp);
    endtask : rdchk

    task automatic settle();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic src(input logic [4:0] v);
        @(posedge sys_clk);
        lvl_req <= v;
        settle();
    endtask : src

    task automatic flags(input logic a, input logic b);
        chk_bit(edge_a_flag, a);
        chk_bit(edge_b_flag, b);
    endtask : flags

    initial begin
        #(8 * 20000);
        mismatches++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        idle_mode = 1'b0;
        lvl_req = 5'h00;
        mismatches = 0;
        num_checks = 0;
        conv_cnt = 0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) rdchk(i[1:0], 16'h0000);
        chk_bit(unit_running, 1'b0);
        $display("test reset done");
        // reserved bit of unit control kept at zero
        wr(2'h0, 16'hEFFF);
        wr(2'h1, 16'hFFFF);
        wr(2'h2, 16'hFFFF);
        wr(2'h3, 16'hFFFF);
        rdchk(2'h0, 16'hAF00);
        rdchk(2'h1, 16'hFFFC);
        rdchk(2'h2, 16'hFF00);
        rdchk(2'h3, 16'h0000);
        chk_bit(unit_running, 1'b1);
        chk_bit(current_sink_ground, 1'b1);
        wr(2'h0, 16'h0000);
        wr(2'h1, 16'h0000);
        settle();
        chk_bit(unit_running, 1'b0);
        chk_bit(current_sink_ground, 1'b0);
        // sink set while the converter samples, unit disabled
        wr(2'h0, 16'h0200);
        settle();
        chk_bit(current_sink_ground, 1'b1);
        wr(2'h0, 16'h0000);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(2'h2, {trim_tab[i], i[1:0], 8'h00});
            settle();
            chk_word({8'h00, current_trim, current_range},
                     {8'h00, trim_tab[i], i[1:0]});
        end
        $display("test current done");
        wr(2'h0, 16'hA800);
        @(posedge sys_clk) idle_mode <= 1'b1;
        settle();
        chk_bit(unit_running, 1'b0);
        @(posedge sys_clk) idle_mode <= 1'b0;
        settle();
        chk_bit(unit_running, 1'b1);
        wr(2'h0, 16'h8800);
        @(posedge sys_clk) idle_mode <= 1'b1;
        settle();
        chk_bit(unit_running, 1'b1);
        @(posedge sys_clk) idle_mode <= 1'b0;
        $display("test idle done");
        wr(2'h1, 16'h4040);
        wr(2'h0, 16'h8D00);
        conv_cnt = 0;
        src(5'b00010);
        flags(1'b0, 1'b0);
        src(5'b00000);
        src(5'b00001);
        flags(1'b1, 1'b0);
        chk_bit(charge_on, 1'b1);
        src(5'b00011);
        flags(1'b1, 1'b1);
        chk_bit(charge_on, 1'b0);
        chk_word(conv_cnt[15:0], 16'h0001);
        wr(2'h0, 16'h8800);
        wr(2'h1, 16'h4040);
        conv_cnt = 0;
        src(5'b00000);
        src(5'b00010);
        flags(1'b0, 1'b1);
        chk_word(conv_cnt[15:0], 16'h0000);
        $display("test order done");
        wr(2'h0, 16'h8000);
        wr(2'h1, 16'h4040);
        src(5'b00000);
        src(5'b00011);
        flags(1'b0, 1'b0);
        wr(2'h1, 16'h4340);
        rdchk(2'h1, 16'h4340);
        flags(1'b1, 1'b1);
        wr(2'h1, 16'h4040);
        rdchk(2'h1, 16'h4040);
        src(5'b00000);
        $display("test software edges done");
        wr(2'h0, 16'h8800);
        wr(2'h1, 16'h4444);
        src(5'b00100);
        flags(1'b1, 1'b1);
        wr(2'h1, 16'h080C);
        src(5'b11000);
        flags(1'b0, 1'b0);
        src(5'b00000);
        flags(1'b1, 1'b1);
        wr(2'h1, 16'h2010);
        src(5'b11111);
        src(5'b00000);
        flags(1'b0, 1'b0);
        // level sense, negative polarity, reserved codes: still silent
        wr(2'h1, 16'hA090);
        settle();
        flags(1'b0, 1'b0);
        $display("test sources done");
        wr(2'h1, 16'hC000);
        src(5'b00001);
        chk_bit(edge_a_flag, 1'b1);
        wr(2'h1, 16'hC000);
        settle();
        chk_bit(edge_a_flag, 1'b1);
        // level hit still seen at the switching edge wins over the clear
        wr(2'h1, 16'h4000);
        settle();
        chk_bit(edge_a_flag, 1'b1);
        wr(2'h1, 16'h4000);
        settle();
        chk_bit(edge_a_flag, 1'b0);
        src(5'b00000);
        $display("test sense done");
        give_verdict();
    end
endmodule : charge_time_edge_control_bench
